// >>> ssr_status.sv
/*
 * System status word readback over the serial interface, wake flags,
 * reset cause capture and the sleep entry reset/supply sequence.
 * Assumes serial pins are asynchronous and much slower than sys_clk_in;
 * event and level inputs come from logic on sys_clk_in.
 */
`timescale 1ns/1ns
`include "ssr_consts.svh"
module ssr_status #(
	parameter int FRAME_BITS = `SSR_FRAME_BITS,
	parameter int CNT_W = 5,
	parameter int DLY_W = 8
) (
	input wire logic sys_clk_in, // system clock, 250 MHz
	input wire logic sys_rst_in, // synchronous reset, active high, power-on
	input wire logic spi_sck_in, // serial clock pin
	input wire logic spi_cs_n_in, // serial chip select pin, active low
	input wire logic spi_mosi_in, // serial data in pin
	output logic spi_miso_out, // serial data out
	output logic spi_miso_oe_out, // serial data out enable
	input wire logic trigger_pin_in, // local wake pin level
	input wire logic can_wake_evt_in, // can wake-up detected pulse
	input wire logic lin_wake_evt_in, // lin wake-up detected pulse
	input wire logic [15:0] rst_evt_in, // reset event pulses, index is cause
	input wire logic normal_mode_entered_in, // normal mode entered pulse
	input wire logic overtemp_warning_in, // temperature warning level
	input wire logic sw_dev_mode_in, // software development mode level
	input wire logic aux_output_state_in, // auxiliary output driven high
	input wire logic sleep_entry_in, // sleep mode entry pulse
	input wire logic wd_off_sel_in, // watchdog off behaviour selected
	input wire logic sleep_exit_in, // sleep mode left pulse
	output logic mode_wr_out, // mode register write pulse
	output logic [11:0] mode_data_out, // mode register write data
	output logic status_read_out, // status word read pulse
	output logic spi_frame_err_out, // frame length error pulse
	output ssr_pkg::ssr_status_t status_snap_out, // word sent in last frame
	output logic reset_out_pin_out, // reset pin drive level
	output logic reset_out_pin_oe_out, // reset pin pull low enable
	output logic wd_disable_out, // watchdog disable
	output logic mcu_supply_en_out // microcontroller supply enable
);
	import ssr_pkg::*;

	localparam int OFF_DLY_CYC =
		(`SSR_SUPPLY_OFF_DLY_NS + `SSR_CLK_PERIOD_NS - 1) / `SSR_CLK_PERIOD_NS;
	localparam logic [DLY_W-1:0] OFF_DLY_LAST = DLY_W'(OFF_DLY_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = '1;
	localparam logic [CNT_W-1:0] CNT_FRAME = CNT_W'(FRAME_BITS);

	logic [3:0] pin_s;
	logic [3:0] pin_d;
	logic sck_rise;
	logic sck_fall;
	logic cs_act;
	logic cs_start;
	logic cs_end;
	logic trig_fall;
	logic [15:0] rx_shift;
	logic [15:0] tx_shift;
	logic [CNT_W-1:0] bit_cnt;
	ssr_cmd_t cmd;
	ssr_status_t cur_status;
	ssr_status_t snap;
	logic frame_ok;
	logic status_rd;
	logic [3:0] reset_cause;
	logic can_wake_flag;
	logic lin_wake_flag;
	logic edge_wake_flag;
	logic power_on_flag;
	ssr_seq_t seq_state;
	logic [DLY_W-1:0] dly_cnt;

	function automatic logic is_status_sel(input ssr_cmd_t c);
		return c.addr_select_bits == `SSR_SEL_ADDR && c.read_bank_select == `SSR_SEL_BANK;
	endfunction

	function automatic logic [3:0] cause_code(input logic [15:0] evt);
		logic [3:0] code;
		code = `SSR_CAUSE_POR;
		for (int i = 15; i >= 0; i--)
			if (evt[i])
				code = 4'(i);
		return code;
	endfunction

	ssr_sync #(
		.WIDTH(4),
		.RESET_VAL(`SSR_PIN_IDLE)
	) u_pin_sync (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in({trigger_pin_in, spi_mosi_in, spi_cs_n_in, spi_sck_in}),
		.sync_out(pin_s)
	);

	// edge detection on the synchronised pins
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			pin_d <= `SSR_PIN_IDLE;
		else
			pin_d <= pin_s;
	end

	assign cs_act = ~pin_s[`SSR_PIN_CS];
	assign cs_start = ~pin_s[`SSR_PIN_CS] & pin_d[`SSR_PIN_CS];
	assign cs_end = pin_s[`SSR_PIN_CS] & ~pin_d[`SSR_PIN_CS];
	assign sck_rise = cs_act & pin_s[`SSR_PIN_SCK] & ~pin_d[`SSR_PIN_SCK];
	assign sck_fall = cs_act & ~pin_s[`SSR_PIN_SCK] & pin_d[`SSR_PIN_SCK];
	assign trig_fall = ~pin_s[`SSR_PIN_TRIG] & pin_d[`SSR_PIN_TRIG];

	// live status word; no gating by operating mode
	always_comb
	begin
		cur_status.addr_select_bits = `SSR_SEL_ADDR;
		cur_status.read_bank_select = `SSR_SEL_BANK;
		cur_status.no_write_flag = 1'h0;
		cur_status.reset_cause = reset_cause;
		cur_status.can_wake_flag = can_wake_flag;
		cur_status.lin_wake_flag = lin_wake_flag;
		cur_status.edge_wake_flag = edge_wake_flag;
		cur_status.trigger_pin_level = pin_s[`SSR_PIN_TRIG];
		cur_status.overtemp_warning = overtemp_warning_in;
		cur_status.sw_dev_mode_flag = sw_dev_mode_in;
		cur_status.aux_output_state = aux_output_state_in;
		cur_status.power_on_flag = power_on_flag;
	end

	// frame shifter: capture on rising, shift out on falling, msb first
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			rx_shift <= 16'h0000;
			tx_shift <= 16'h0000;
			bit_cnt <= '0;
			snap <= '0;
		end
		else if (cs_start)
		begin
			tx_shift <= cur_status;
			snap <= cur_status;
			bit_cnt <= '0;
		end
		else
		begin
			if (sck_rise)
			begin
				rx_shift <= {rx_shift[14:0], pin_s[`SSR_PIN_MOSI]};
				if (bit_cnt != CNT_FULL)
					bit_cnt <= bit_cnt + 1'h1;
			end
			if (sck_fall && bit_cnt != '0)
				tx_shift <= {tx_shift[14:0], 1'h0};
		end
	end

	assign spi_miso_out = tx_shift[15];
	assign spi_miso_oe_out = cs_act;
	assign status_snap_out = snap;

	assign cmd = rx_shift;
	assign frame_ok = bit_cnt == CNT_FRAME;
	assign status_rd = cs_end & frame_ok & is_status_sel(cmd);

	// command decode at frame end
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			mode_wr_out <= 1'h0;
			mode_data_out <= 12'h000;
			status_read_out <= 1'h0;
			spi_frame_err_out <= 1'h0;
		end
		else
		begin
			status_read_out <= status_rd;
			mode_wr_out <= status_rd & (cmd.no_write_flag != `SSR_NO_WRITE);
			if (status_rd && cmd.no_write_flag != `SSR_NO_WRITE)
				mode_data_out <= cmd.mode_data;
			spi_frame_err_out <= cs_end & ~frame_ok;
		end
	end

	// wake flags: a new event wins over a read clear
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			can_wake_flag <= 1'h0;
			lin_wake_flag <= 1'h0;
			edge_wake_flag <= 1'h0;
		end
		else
		begin
			can_wake_flag <= (can_wake_flag & ~(status_rd & snap.can_wake_flag))
				| can_wake_evt_in;
			lin_wake_flag <= (lin_wake_flag & ~(status_rd & snap.lin_wake_flag))
				| lin_wake_evt_in;
			edge_wake_flag <= (edge_wake_flag & ~(status_rd & snap.edge_wake_flag))
				| trig_fall;
		end
	end

	// reset cause holds the latest event; lowest code wins a tie
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			reset_cause <= `SSR_CAUSE_POR;
		else if (rst_evt_in != 16'h0000)
			reset_cause <= cause_code(rst_evt_in);
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			power_on_flag <= 1'h1;
		else if (normal_mode_entered_in)
			power_on_flag <= 1'h0;
	end

	// sleep entry with watchdog off: reset pin first, supply later
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			seq_state <= SSR_RUN;
			dly_cnt <= '0;
		end
		else
		begin
			case (seq_state)
				SSR_RUN:
				begin
					dly_cnt <= '0;
					if (sleep_entry_in && wd_off_sel_in)
						seq_state <= SSR_RST_LOW;
				end
				SSR_RST_LOW:
				begin
					dly_cnt <= dly_cnt + 1'h1;
					if (dly_cnt == OFF_DLY_LAST)
						seq_state <= SSR_SUPPLY_OFF;
				end
				SSR_SUPPLY_OFF:
				begin
					if (sleep_exit_in)
						seq_state <= SSR_RUN;
				end
				default:
					seq_state <= SSR_RUN;
			endcase
		end
	end

	assign reset_out_pin_out = 1'h0;
	assign reset_out_pin_oe_out = seq_state != SSR_RUN;
	assign wd_disable_out = seq_state != SSR_RUN;
	assign mcu_supply_en_out = seq_state != SSR_SUPPLY_OFF;

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	a_cause_latest: assert property (
		rst_evt_in != 16'h0000 |=> reset_cause == cause_code($past(rst_evt_in)))
		else $error("reset cause not updated to latest event");

	a_cause_holds: assert property (
		rst_evt_in == 16'h0000 |=> reset_cause == $past(reset_cause))
		else $error("reset cause changed without an event");

	a_por_clear: assert property (
		normal_mode_entered_in |=> !power_on_flag [*2])
		else $error("power-on flag not cleared by normal mode entry");

	a_can_set: assert property (
		can_wake_evt_in |=> can_wake_flag)
		else $error("can wake flag not set by event");

	a_lin_clear: assert property (
		status_rd && snap.lin_wake_flag && !lin_wake_evt_in |=> !lin_wake_flag)
		else $error("lin wake flag not cleared by status read");

	a_edge_wake: assert property (
		$fell(pin_s[`SSR_PIN_TRIG]) |=> edge_wake_flag)
		else $error("edge wake flag missed a falling pin edge");

	a_ro_no_write: assert property (
		status_rd && cmd.no_write_flag == `SSR_NO_WRITE |=> !mode_wr_out)
		else $error("mode register written on a no-write read");

	a_mode_write: assert property (
		status_rd && cmd.no_write_flag != `SSR_NO_WRITE
		|=> mode_wr_out && status_read_out && mode_data_out == $past(cmd.mode_data))
		else $error("mode register not loaded on a writing read");

	a_first_bit: assert property (
		cs_start |=> spi_miso_out == $past(cur_status[15]) && spi_miso_oe_out
			&& status_snap_out == $past(cur_status))
		else $error("first status bit not presented at frame start");

	a_rst_first: assert property (
		seq_state == SSR_RUN && sleep_entry_in && wd_off_sel_in
		|=> reset_out_pin_oe_out && wd_disable_out && mcu_supply_en_out)
		else $error("reset pin not pulled before supply switch-off");

	a_off_needs_rst: assert property (
		!mcu_supply_en_out |-> reset_out_pin_oe_out && $past(reset_out_pin_oe_out))
		else $error("supply off without reset pin held low");

	a_frame_len: assert property (
		cs_end && !frame_ok |=> spi_frame_err_out && !status_read_out && !mode_wr_out)
		else $error("bad frame length not flagged");
endmodule

// >>> ssr_consts.svh
/*
 * Constants of the system status readback block: frame layout, selector
 * values, reset cause codes, pin indices and sleep entry timing.
 * Assumes it is included by bare name, once per compilation unit.
 */
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH

`define SSR_FRAME_BITS 16
`define SSR_SEL_ADDR 2'h0
`define SSR_SEL_BANK 1'h0
`define SSR_NO_WRITE 1'h1

`define SSR_CAUSE_POR 4'h0
`define SSR_CAUSE_CYCLIC 4'h1
`define SSR_CAUSE_LOW_SUPPLY 4'h2
`define SSR_CAUSE_CURRENT 4'h3
`define SSR_CAUSE_AUX_OVL 4'h4
`define SSR_CAUSE_FLASH_LEFT 4'h5
`define SSR_CAUSE_FLASH_READY 4'h6
`define SSR_CAUSE_CAN_WAKE 4'h7
`define SSR_CAUSE_LIN_WAKE 4'h8
`define SSR_CAUSE_PIN_WAKE 4'h9
`define SSR_CAUSE_FAILSAFE 4'hA
`define SSR_CAUSE_WD_OVF 4'hB
`define SSR_CAUSE_WD_INIT 4'hC
`define SSR_CAUSE_WD_EARLY 4'hD
`define SSR_CAUSE_ILLEGAL_SPI 4'hE
`define SSR_CAUSE_IRQ_TIMEOUT 4'hF

`define SSR_PIN_SCK 0
`define SSR_PIN_CS 1
`define SSR_PIN_MOSI 2
`define SSR_PIN_TRIG 3
`define SSR_PIN_IDLE 4'h2

`define SSR_CLK_PERIOD_NS 4
`define SSR_SUPPLY_OFF_DLY_NS 200

`endif

// >>> ssr_pkg.sv
/*
 * Types of the system status readback block: the status word layout,
 * the incoming command frame layout and the sleep entry sequence states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ssr_pkg;

	typedef struct packed {
		logic [1:0] addr_select_bits;
		logic read_bank_select;
		logic no_write_flag;
		logic [3:0] reset_cause;
		logic can_wake_flag;
		logic lin_wake_flag;
		logic edge_wake_flag;
		logic trigger_pin_level;
		logic overtemp_warning;
		logic sw_dev_mode_flag;
		logic aux_output_state;
		logic power_on_flag;
	} ssr_status_t;

	typedef struct packed {
		logic [1:0] addr_select_bits;
		logic read_bank_select;
		logic no_write_flag;
		logic [11:0] mode_data;
	} ssr_cmd_t;

	typedef enum logic [1:0] {
		SSR_RUN,
		SSR_RST_LOW,
		SSR_SUPPLY_OFF
	} ssr_seq_t;

endpackage

// >>> ssr_sync.sv
/*
 * Two flip-flop synchroniser bank for pin inputs.
 * Assumes each bit is an independent level; the reset value is per bit.
 */
`timescale 1ns/1ns
module ssr_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic sys_clk_in, // system clock
	input wire logic sys_rst_in, // synchronous reset, active high
	input wire logic [WIDTH-1:0] async_in, // asynchronous levels
	output logic [WIDTH-1:0] sync_out // synchronised levels
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			meta <= RESET_VAL;
			sync_out <= RESET_VAL;
		end
		else
		begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// >>> ssr_host.sv
/*
 * Host model: drives the serial frame pins, mode 0, msb first.
 * Assumes sys_clk_in comes from the bench; each half of sck lasts 4 cycles.
 */
`timescale 1ns/1ns
module ssr_host (
	input wire logic sys_clk_in, // system clock
	input wire logic miso_in, // serial data from device
	output logic sck_out, // serial clock
	output logic cs_n_out, // chip select, active low
	output logic mosi_out // serial data to device
);
	initial
	begin
		sck_out = 1'h0;
		cs_n_out = 1'h1;
		mosi_out = 1'h0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	// sends the top n bits of tx; rx gathers the returned bits
	task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = '0;
		cs_n_out <= 1'h0;
		wait_clk(4);
		for (int i = 15; i > 15 - n; i--)
		begin
			mosi_out <= tx[i];
			wait_clk(4);
			sck_out <= 1'h1;
			rx[i] = miso_in;
			wait_clk(4);
			sck_out <= 1'h0;
		end
		wait_clk(4);
		cs_n_out <= 1'h1;
		mosi_out <= ~mosi_out;
		wait_clk(6);
	endtask
endmodule

// >>> ssr_status_tb_top.sv
/*
 * Testbench of the status readback block: frames via the host model,
 * events and levels driven here, pulses counted and compared.
 * Assumes default parameters of the block.
 */
`timescale 1ns/1ns
module ssr_status_tb_top;
	import ssr_pkg::*;
	logic sys_clk_in = 1'h0;
	logic sys_rst_in = 1'h1;
	logic trig = 1'h1, can_evt = 1'h0, lin_evt = 1'h0, nm_evt = 1'h0;
	logic ot = 1'h0, sd = 1'h0, aux = 1'h0, slp = 1'h0, wd_off = 1'h0, wake = 1'h0;
	logic [15:0] rst_evt = 16'h0;
	logic sck, cs_n, mosi, miso, miso_oe, mode_wr, rd_p, err_p, pin, oe, wd, sup;
	logic [11:0] mode_data;
	ssr_status_t snap;
	logic [15:0] rx;
	int mismatches = 0, compares = 0, cycles = 0, n_rd = 0, n_wr = 0, n_err = 0, n_oe = 0;
	always #2 sys_clk_in = ~sys_clk_in;
	ssr_host u_host (.sys_clk_in(sys_clk_in), .miso_in(miso), .sck_out(sck),
		.cs_n_out(cs_n), .mosi_out(mosi));
	ssr_status u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .spi_sck_in(sck),
		.spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
		.spi_miso_oe_out(miso_oe), .trigger_pin_in(trig), .can_wake_evt_in(can_evt),
		.lin_wake_evt_in(lin_evt), .rst_evt_in(rst_evt), .normal_mode_entered_in(nm_evt),
		.overtemp_warning_in(ot), .sw_dev_mode_in(sd), .aux_output_state_in(aux),
		.sleep_entry_in(slp), .wd_off_sel_in(wd_off), .sleep_exit_in(wake),
		.mode_wr_out(mode_wr), .mode_data_out(mode_data), .status_read_out(rd_p),
		.spi_frame_err_out(err_p), .status_snap_out(snap), .reset_out_pin_out(pin),
		.reset_out_pin_oe_out(oe), .wd_disable_out(wd), .mcu_supply_en_out(sup));
	task automatic give_verdict();
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	always @(posedge sys_clk_in)
	begin
		cycles <= cycles + 1;
		if (!sys_rst_in)
		begin
			n_rd <= n_rd + int'(rd_p === 1'h1);
			n_wr <= n_wr + int'(mode_wr === 1'h1);
			n_err <= n_err + int'(err_p === 1'h1);
			n_oe <= n_oe + int'(miso_oe === 1'h1);
		end
		if (cycles == 20000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic rd(input logic [15:0] cmd, input logic [15:0] exp);
		u_host.xfer(cmd, 16, rx);
		chk(rx, exp);
		chk(snap, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	// samples the sleep outputs just after an edge, then realigns to the edge
	task automatic sleep_chk(input int n, input logic [3:0] exp);
		tick(n);
		#1;
		chk(16'({wd, oe, pin, sup}), 16'(exp));
		tick(1);
	endtask
	initial
	begin
		tick(2);
		sys_rst_in <= 1'h0;
		tick(3);
		rd(16'h1000, 16'h0011);
		chk(16'(n_wr), 16'h0);
		chk(16'(n_rd), 16'h1);
		chk(16'(n_oe), 16'd136);
		for (int i = 0; i < 16; i++)
		begin
			rst_evt <= 16'h1 << i;
			{ot, sd, aux} <= i[2:0];
			tick(1);
			rst_evt <= 16'h0;
			rd(16'h1000, {4'h0, i[3:0], 3'h0, 1'h1, i[2:0], 1'h1});
		end
		rd(16'h1000, 16'h0F1F);
		{ot, sd, aux} <= 3'h0;
		can_evt <= 1'h1;
		lin_evt <= 1'h1;
		trig <= 1'h0;
		tick(1);
		can_evt <= 1'h0;
		lin_evt <= 1'h0;
		tick(6);
		rd(16'h0A5C, 16'h0FE1);
		chk(16'(n_wr), 16'h1);
		chk({4'h0, mode_data}, 16'h0A5C);
		rd(16'h1000, 16'h0F01);
		chk(16'(n_wr), 16'h1);
		nm_evt <= 1'h1;
		trig <= 1'h1;
		tick(1);
		nm_evt <= 1'h0;
		tick(6);
		rd(16'h1000, 16'h0F10);
		u_host.xfer(16'h4000, 16, rx);
		u_host.xfer(16'h2000, 16, rx);
		chk(16'(n_rd), 16'd21);
		chk(16'(n_wr), 16'h1);
		u_host.xfer(16'h1000, 8, rx);
		chk(16'(n_err), 16'h1);
		chk(16'(n_rd), 16'd21);
		slp <= 1'h1;
		tick(1);
		slp <= 1'h0;
		sleep_chk(3, 4'h1);
		slp <= 1'h1;
		wd_off <= 1'h1;
		tick(1);
		slp <= 1'h0;
		sleep_chk(0, 4'hD);
		sleep_chk(47, 4'hD);
		sleep_chk(0, 4'hD);
		sleep_chk(0, 4'hC);
		rd(16'h1000, 16'h0F10);
		sleep_chk(0, 4'hC);
		wake <= 1'h1;
		tick(1);
		wake <= 1'h0;
		sleep_chk(0, 4'h1);
		sys_rst_in <= 1'h1;
		tick(2);
		sys_rst_in <= 1'h0;
		tick(3);
		rd(16'h1000, 16'h0011);
		give_verdict();
	end
endmodule
